// file: acc_adc_config.sv
// register file, start hold-off, settling and trim for the converters
// What this block does
// - status bit reads 1 while main converter runs, 0 when off
// - aux cell result valid after 4.3, 2.3 or 1.3 ms settling
// - cell filter code selects cut-off 6.5 to 600 Hz
// - filter codes 5 and 7 both select the 240 Hz cut-off
// - busbar filter field uses the same code mapping as the cell
// - after start, converter enable waits for the programmed delay
// - delay is code times 5 us, from 0 to 200 us
// - delay codes beyond 200 us mean no delay
// - low gain trim byte has a register of its own
// - gain trim top bit is bit 7 of the second trim register
// - nine-bit gain trim spans about plus or minus 0.78 percent
// - seven-bit offset trim in bits 6..0, 0.19073 mV steps
// - trims are applied to main results without host action
// - gain trim copied from one-time memory at every reset
// - offset trim copied from one-time memory at every reset
// - start bit acts on write of 1, ignores 0, reads 0
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module acc_adc_config #(
    parameter int SAMPLE_W = 16,
    parameter int SETTLE_SLOW = acc_pkg::SETTLE_SLOW_CYC,
    parameter int SETTLE_MID = acc_pkg::SETTLE_MID_CYC,
    parameter int SETTLE_FAST = acc_pkg::SETTLE_FAST_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input acc_pkg::acc_reg_req_t regReq,
    output logic [7:0] rdData,
    input acc_pkg::acc_trim_t otpTrim,
    input wire logic mainDone,
    output logic mainEnable,
    input wire logic auxMeasStart,
    output logic auxMeasValid,
    output acc_pkg::acc_filter_t filterCfg,
    input wire logic sampleValid,
    input wire logic signed [SAMPLE_W-1:0] sampleIn,
    output logic corrValid,
    output logic signed [SAMPLE_W-1:0] corrOut
);
    import acc_pkg::*;

    localparam int SETTLE_W = 18;

    ////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0] filterReg_r;
    logic [7:0] filterReg_nxt;
    logic [7:0] delayReg_r;
    logic [7:0] delayReg_nxt;
    logic [7:0] gainLow_r;
    logic [7:0] gainLow_nxt;
    logic [7:0] gainOffset_r;
    logic [7:0] gainOffset_nxt;
    logic trimLoad_r;
    logic [7:0] rdData_r;
    logic [7:0] rdData_nxt;
    logic startPulse;
    acc_state_t state_r;
    acc_state_t state_nxt;
    logic auxOk_r;

    // one-time memory is caught the first edge after reset release
    always_comb begin
        filterReg_nxt = filterReg_r;
        delayReg_nxt = delayReg_r;
        gainLow_nxt = gainLow_r;
        gainOffset_nxt = gainOffset_r;
        startPulse = 1'b0;
        if (trimLoad_r) begin
            gainLow_nxt = otpTrim.gain[7:0];
            gainOffset_nxt = {otpTrim.gain[8], otpTrim.offset};
        end else if (regReq.wrStb) begin
            if (regReq.addr == OFS_FILTER_CFG) begin
                filterReg_nxt = regReq.wrData;
            end else if (regReq.addr == OFS_START_DELAY) begin
                delayReg_nxt = regReq.wrData;
            end else if (regReq.addr == OFS_GAIN_LOW) begin
                gainLow_nxt = regReq.wrData;
            end else if (regReq.addr == OFS_GAIN_OFFSET) begin
                gainOffset_nxt = regReq.wrData;
            end else if (regReq.addr == OFS_CONV_CTRL) begin
                startPulse = regReq.wrData[START_BIT];
            end
        end
        if (trimLoad_r && regReq.wrStb && regReq.addr == OFS_CONV_CTRL) begin
            startPulse = regReq.wrData[START_BIT];
        end
    end

    // start bit has no storage, so it always reads back as 0
    always_comb begin
        rdData_nxt = 8'h00;
        if (regReq.rdStb) begin
            if (regReq.addr == OFS_FILTER_CFG) begin
                rdData_nxt = filterReg_r;
            end else if (regReq.addr == OFS_START_DELAY) begin
                rdData_nxt = delayReg_r;
            end else if (regReq.addr == OFS_GAIN_LOW) begin
                rdData_nxt = gainLow_r;
            end else if (regReq.addr == OFS_GAIN_OFFSET) begin
                rdData_nxt = gainOffset_r;
            end else if (regReq.addr == OFS_CONV_STATUS) begin
                rdData_nxt[RUN_BIT] = (state_r == ST_RUN);
                rdData_nxt[AUX_OK_BIT] = auxOk_r;
            end else if (regReq.addr == OFS_CONV_CTRL) begin
                rdData_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            filterReg_r <= RST_FILTER_CFG;
            delayReg_r <= RST_START_DELAY;
            gainLow_r <= RST_GAIN_LOW;
            gainOffset_r <= RST_GAIN_OFFSET;
            trimLoad_r <= 1'b1;
            rdData_r <= 8'h00;
        end else begin
            filterReg_r <= filterReg_nxt;
            delayReg_r <= delayReg_nxt;
            gainLow_r <= gainLow_nxt;
            gainOffset_r <= gainOffset_nxt;
            trimLoad_r <= 1'b0;
            rdData_r <= rdData_nxt;
        end
    end

    assign rdData = rdData_r;

    ////////////////////////////////////////////////////////////////////
    // filter cut-off selection

    acc_filter_t filter_r;
    acc_filter_t filter_nxt;

    // aliases folded here so the filter sees one code per cut-off
    always_comb begin
        filter_nxt.cellCutoff = filterReg_r[CELL_LSB +: 3];
        filter_nxt.busbarCutoff = filterReg_r[BUSBAR_LSB +: 3];
        if (filter_nxt.cellCutoff == CUT_240_ALIAS) begin
            filter_nxt.cellCutoff = CUT_240;
        end
        if (filter_nxt.busbarCutoff == CUT_240_ALIAS) begin
            filter_nxt.busbarCutoff = CUT_240;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            filter_r <= '0;
        end else begin
            filter_r <= filter_nxt;
        end
    end

    assign filterCfg = filter_r;

    ////////////////////////////////////////////////////////////////////
    // main converter start sequence

    logic holdBusy;
    logic holdDone;

    acc_start_holdoff #(
        .CNT_W(12)
    ) u_holdoff (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(startPulse),
        .delayCode(delayReg_r[DELAY_LSB +: 6]),
        .busy(holdBusy),
        .done(holdDone)
    );

    // a new start while running restarts the hold-off, as a re-arm
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (startPulse) begin
                    state_nxt = holdDone ? ST_RUN : ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (holdDone) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (startPulse) begin
                    state_nxt = holdDone ? ST_RUN : ST_HOLD;
                end else if (mainDone) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign mainEnable = (state_r == ST_RUN);

    ////////////////////////////////////////////////////////////////////
    // auxiliary settling timer

    logic [SETTLE_W-1:0] settleCnt_r;
    logic [SETTLE_W-1:0] settleCnt_nxt;
    logic auxOk_nxt;
    logic [SETTLE_W-1:0] settleLoad;

    // reserved code takes the longest wait, the safe side
    always_comb begin
        case (filterReg_r[SETTLE_LSB +: 2])
            acc_pkg::SETTLE_MID: settleLoad = SETTLE_W'(SETTLE_MID);
            acc_pkg::SETTLE_FAST: settleLoad = SETTLE_W'(SETTLE_FAST);
            default: settleLoad = SETTLE_W'(SETTLE_SLOW);
        endcase
        settleCnt_nxt = settleCnt_r;
        auxOk_nxt = auxOk_r;
        if (auxMeasStart) begin
            settleCnt_nxt = settleLoad;
            auxOk_nxt = 1'b0;
        end else if (settleCnt_r != '0) begin
            settleCnt_nxt = settleCnt_r - 1'b1;
            auxOk_nxt = (settleCnt_r == SETTLE_W'(1));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            settleCnt_r <= '0;
            auxOk_r <= 1'b0;
        end else begin
            settleCnt_r <= settleCnt_nxt;
            auxOk_r <= auxOk_nxt;
        end
    end

    assign auxMeasValid = auxOk_r;

    ////////////////////////////////////////////////////////////////////
    // result correction

    acc_trim_t trimNow;

    assign trimNow.gain = {gainOffset_r[GAIN_TOP_BIT],
        gainLow_r};
    assign trimNow.offset = gainOffset_r[6:0];

    acc_trim_correct #(
        .SAMPLE_W(SAMPLE_W)
    ) u_correct (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .trim(trimNow),
        .inValid(sampleValid),
        .inData(sampleIn),
        .outValid(corrValid),
        .outData(corrOut)
    );

    ////////////////////////////////////////////////////////////////////
    // checks

    property p_status_run;
        @(posedge ref_clk) disable iff (!rst_n)
        regReq.rdStb && regReq.addr == OFS_CONV_STATUS
        |=> rdData[RUN_BIT] == $past(mainEnable);
    endproperty
    a_status_run: assert property (p_status_run)
        else $error("run status bit disagrees with converter state");

    property p_settle_fast;
        @(posedge ref_clk) disable iff (!rst_n)
        auxMeasStart && filterReg_r[7:6] == 2'h2
        |=> settleCnt_r == SETTLE_W'(SETTLE_FAST) && !auxMeasValid;
    endproperty
    a_settle_fast: assert property (p_settle_fast)
        else $error("fast settling time not loaded");

    property p_alias;
        @(posedge ref_clk) disable iff (!rst_n)
        filterReg_r[2:0] == 3'h7 |=> filterCfg.cellCutoff == 3'h5;
    endproperty
    a_alias: assert property (p_alias)
        else $error("filter code 7 not mapped to 240 Hz");

    property p_busbar_same;
        @(posedge ref_clk) disable iff (!rst_n)
        filterReg_r[5:3] == filterReg_r[2:0] && $stable(filterReg_r)
        |=> filterCfg.busbarCutoff == filterCfg.cellCutoff;
    endproperty
    a_busbar_same: assert property (p_busbar_same)
        else $error("busbar mapping differs from cell mapping");

    sequence s_start_nodelay;
        startPulse && delayReg_r[5:0] == 6'h00;
    endsequence

    property p_start_now;
        @(posedge ref_clk) disable iff (!rst_n)
        s_start_nodelay |=> mainEnable;
    endproperty
    a_start_now: assert property (p_start_now)
        else $error("zero delay start did not enable converter");

    property p_start_wait;
        @(posedge ref_clk) disable iff (!rst_n)
        startPulse && delayReg_r[5:0] == 6'h01 ##1 !startPulse[*8]
        |-> !mainEnable;
    endproperty
    a_start_wait: assert property (p_start_wait)
        else $error("converter enabled before hold-off ended");

    property p_ctrl_reads_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        regReq.rdStb && regReq.addr == OFS_CONV_CTRL |=> rdData == 8'h00;
    endproperty
    a_ctrl_reads_zero: assert property (p_ctrl_reads_zero)
        else $error("start bit did not read back as zero");

    property p_trim_load;
        @(posedge ref_clk) disable iff (!rst_n)
        rst_n && trimLoad_r |=> trimNow.gain == $past(otpTrim.gain)
            && trimNow.offset == $past(otpTrim.offset);
    endproperty
    a_trim_load: assert property (p_trim_load)
        else $error("trim not copied from one-time memory");

    property p_no_trim_pass;
        @(posedge ref_clk) disable iff (!rst_n)
        sampleValid && trimNow == '0 |=> corrValid
            && corrOut == $past(sampleIn);
    endproperty
    a_no_trim_pass: assert property (p_no_trim_pass)
        else $error("zero trim changed the result");
endmodule

// file: acc_pkg.sv
// shared constants and types for the converter configuration block
package acc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [11:0] OFS_FILTER_CFG = 12'h007;
    localparam logic [11:0] OFS_START_DELAY = 12'h008;
    localparam logic [11:0] OFS_GAIN_LOW = 12'h01b;
    localparam logic [11:0] OFS_GAIN_OFFSET = 12'h01c;
    localparam logic [11:0] OFS_CONV_STATUS = 12'h0c0;
    localparam logic [11:0] OFS_CONV_CTRL = 12'h30d;

    // field positions
    localparam int CELL_LSB = 0;
    localparam int BUSBAR_LSB = 3;
    localparam int SETTLE_LSB = 6;
    localparam int DELAY_LSB = 0;
    localparam int GAIN_TOP_BIT = 7;
    localparam int START_BIT = 2;
    localparam int RUN_BIT = 0;
    localparam int AUX_OK_BIT = 1;

    // reset values
    localparam logic [7:0] RST_FILTER_CFG = 8'h00;
    localparam logic [7:0] RST_START_DELAY = 8'h00;
    localparam logic [7:0] RST_GAIN_LOW = 8'h00;
    localparam logic [7:0] RST_GAIN_OFFSET = 8'h00;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int STEP_US = 5;
    localparam int STEP_CYC = (STEP_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int MAX_DELAY_US = 200;
    localparam logic [5:0] MAX_DELAY_CODE = 6'(MAX_DELAY_US / STEP_US);
    localparam int SETTLE_SLOW_US = 4300; // 4.3 ms
    localparam int SETTLE_MID_US = 2300; // 2.3 ms
    localparam int SETTLE_FAST_US = 1300; // 1.3 ms
    localparam int SETTLE_SLOW_CYC = (SETTLE_SLOW_US * 1000
        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_MID_CYC = (SETTLE_MID_US * 1000
        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_FAST_CYC = (SETTLE_FAST_US * 1000
        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] SETTLE_SLOW = 2'h0;
    localparam logic [1:0] SETTLE_MID = 2'h1;
    localparam logic [1:0] SETTLE_FAST = 2'h2;

    // filter codes 0x5 and 0x7 share one cut-off
    localparam logic [2:0] CUT_240 = 3'h5;
    localparam logic [2:0] CUT_240_ALIAS = 3'h7;

    localparam int GAIN_FRAC = 15;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b100
    } acc_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wrData;
        logic wrStb;
        logic rdStb;
    } acc_reg_req_t;

    typedef struct packed {
        logic [8:0] gain;
        logic [6:0] offset;
    } acc_trim_t;

    typedef struct packed {
        logic [2:0] cellCutoff;
        logic [2:0] busbarCutoff;
    } acc_filter_t;
endpackage

// file: acc_start_holdoff.sv
// programmable hold-off between start command and converter enable
`timescale 1ns/1ps
module acc_start_holdoff #(
    parameter int CNT_W = 12
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [5:0] delayCode,
    output logic busy,
    output logic done
);
    import acc_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [5:0] effCode;
    logic [CNT_W-1:0] loadVal;

    always_comb begin
        effCode = (delayCode > MAX_DELAY_CODE) ? 6'h00 : delayCode;
        loadVal = CNT_W'(effCode * STEP_CYC);
        cnt_nxt = cnt_r;
        done = 1'b0;
        if (start) begin
            cnt_nxt = loadVal;
            done = (loadVal == '0);
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
            done = (cnt_r == CNT_W'(1));
        end
    end

    assign busy = (cnt_r != '0);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    property p_zero_now;
        @(posedge ref_clk) disable iff (!rst_n)
        start && (delayCode == 6'h00 || delayCode > 6'h28) |-> done;
    endproperty
    a_zero_now: assert property (p_zero_now)
        else $error("zero or undefined delay code did not start at once");

    property p_step_load;
        @(posedge ref_clk) disable iff (!rst_n)
        start && delayCode == 6'h01 |=> cnt_r == 12'd100 && !done;
    endproperty
    a_step_load: assert property (p_step_load)
        else $error("one delay step is not 100 cycles");

    property p_max_load;
        @(posedge ref_clk) disable iff (!rst_n)
        start && delayCode == 6'h28 |=> cnt_r == 12'd4000;
    endproperty
    a_max_load: assert property (p_max_load)
        else $error("largest delay is not 200 us");

    property p_count_down;
        @(posedge ref_clk) disable iff (!rst_n)
        busy && !start |=> cnt_r == $past(cnt_r) - 12'd1;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("hold-off counter did not step down");
endmodule

// file: acc_trim_correct.sv
// applies signed gain and offset trim to main conversion results
`timescale 1ns/1ps
module acc_trim_correct #(
    parameter int SAMPLE_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input acc_pkg::acc_trim_t trim,
    input wire logic inValid,
    input wire logic signed [SAMPLE_W-1:0] inData,
    output logic outValid,
    output logic signed [SAMPLE_W-1:0] outData
);
    import acc_pkg::*;

    localparam int PROD_W = SAMPLE_W + 9;
    localparam int SUM_W = SAMPLE_W + 2;
    localparam logic signed [SUM_W-1:0] SAT_MAX =
        SUM_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
    localparam logic signed [SUM_W-1:0] SAT_MIN =
        -SAT_MAX - SUM_W'(1);

    logic signed [PROD_W-1:0] prod;
    logic signed [SUM_W-1:0] sum;
    logic signed [SAMPLE_W-1:0] outData_nxt;
    logic outValid_r;
    logic signed [SAMPLE_W-1:0] outData_r;

    // trims are two's complement; one gain code is 2^-15 of full value
    always_comb begin
        prod = PROD_W'(inData) * PROD_W'($signed(trim.gain));
        sum = SUM_W'(inData) + SUM_W'(prod >>> GAIN_FRAC)
            + SUM_W'($signed(trim.offset));
        if (sum > SAT_MAX) begin
            outData_nxt = SAMPLE_W'(SAT_MAX);
        end else if (sum < SAT_MIN) begin
            outData_nxt = SAMPLE_W'(SAT_MIN);
        end else begin
            outData_nxt = SAMPLE_W'(sum);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            outValid_r <= 1'b0;
            outData_r <= '0;
        end else begin
            outValid_r <= inValid;
            outData_r <= inValid ? outData_nxt : outData_r;
        end
    end

    assign outValid = outValid_r;
    assign outData = outData_r;
endmodule

// file: tb_acc_adc_config.sv
// self-checking bench for the converter configuration block
`timescale 1ns/1ps
module tb_acc_adc_config;
    import acc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    acc_reg_req_t regReq = '0;
    logic [7:0] rdData;
    acc_trim_t otpTrim = '0;
    logic mainDone = 1'b0;
    logic mainEnable;
    logic auxMeasStart = 1'b0;
    logic auxMeasValid;
    acc_filter_t filterCfg;
    logic sampleValid = 1'b0;
    logic signed [15:0] sampleIn = '0;
    logic corrValid;
    logic signed [15:0] corrOut;
    int fail_count = 0;
    int total_checks = 0;
    int seed = 83;
    int cycleCount = 0;
    logic rdPend = 1'b0;
    logic [7:0] rdQ[$];
    logic [15:0] corrQ[$];
    // settle counts shortened so the run stays short
    acc_adc_config #(.SETTLE_SLOW(40), .SETTLE_MID(30), .SETTLE_FAST(20))
        dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .regReq(regReq),
        .rdData(rdData), .otpTrim(otpTrim), .mainDone(mainDone),
        .mainEnable(mainEnable), .auxMeasStart(auxMeasStart),
        .auxMeasValid(auxMeasValid), .filterCfg(filterCfg),
        .sampleValid(sampleValid), .sampleIn(sampleIn),
        .corrValid(corrValid), .corrOut(corrOut));
    always #25 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t got %h expected %h", $time, got,
                exp);
        end
    endtask
    always @(posedge ref_clk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // result monitors take the oldest note off each queue
    always @(posedge ref_clk) rdPend <= regReq.rdStb;
    always @(negedge ref_clk) begin
        if (rdPend) begin
            chk({8'h00, rdData}, {8'h00, rdQ.pop_front()});
        end else begin
            chk({8'h00, rdData}, 16'h0000);
        end
        if (corrValid === 1'b1) begin
            if (corrQ.size() == 0) begin
                chk(corrOut, 16'hxxxx);
            end else begin
                chk(corrOut, corrQ.pop_front());
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regReq.addr <= a;
        regReq.wrData <= d;
        regReq.wrStb <= 1'b1;
        @(posedge ref_clk);
        regReq.wrStb <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        rdQ.push_back(e);
        regReq.addr <= a;
        regReq.rdStb <= 1'b1;
        @(posedge ref_clk);
        regReq.rdStb <= 1'b0;
    endtask
    task automatic do_reset(input acc_trim_t t);
        rst_n <= 1'b0;
        otpTrim <= t;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    // counts edges from launch until the watched output first rises
    task automatic launch(input bit aux, input int expCnt);
        int cnt;
        cnt = 0;
        @(posedge ref_clk);
        if (aux) begin
            auxMeasStart <= 1'b1;
        end else begin
            regReq.addr <= OFS_CONV_CTRL;
            regReq.wrData <= 8'h04;
            regReq.wrStb <= 1'b1;
        end
        do begin
            @(posedge ref_clk);
            auxMeasStart <= 1'b0;
            regReq.wrStb <= 1'b0;
            cnt++;
            #1;
        end while ((aux ? auxMeasValid : mainEnable) !== 1'b1 && cnt < 5000);
        chk(16'(cnt), 16'(expCnt));
    endtask
    function automatic logic [15:0] corr(input logic signed [15:0] x,
        input logic signed [8:0] g, input logic signed [6:0] o);
        longint v;
        v = longint'(x) + ((longint'(x) * longint'(g)) >>> 15)
            + longint'(o);
        if (v > 32767) v = 32767;
        if (v < -32768) v = -32768;
        return v[15:0];
    endfunction
    ////////////////////////////////////////////////////////////////////
    initial begin
        acc_trim_t t;
        logic [8:0] g;
        logic [6:0] o;
        logic [5:0] codes[6];
        logic signed [15:0] x;
        codes = '{6'd0, 6'd1, 6'd3, 6'd40, 6'd41, 6'd63};
        // second reset mid-run must reload the one-time trims
        for (int r = 0; r < 2; r++) begin
            t = acc_trim_t'($random(seed));
            do_reset(t);
            rd(OFS_GAIN_LOW, t.gain[7:0]);
            rd(OFS_GAIN_OFFSET, {t.gain[8], t.offset});
            rd(OFS_FILTER_CFG, RST_FILTER_CFG);
            rd(OFS_START_DELAY, RST_START_DELAY);
            rd(OFS_CONV_STATUS, 8'h00);
        end
        wr(12'h123, 8'hff);
        rd(12'h123, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(OFS_FILTER_CFG, {2'h0, 3'(7 - c), 3'(c)});
            rd(OFS_FILTER_CFG, {2'h0, 3'(7 - c), 3'(c)});
            @(negedge ref_clk);
            chk(16'(filterCfg.cellCutoff),
                (c == 7) ? 16'h5 : 16'(c));
            chk(16'(filterCfg.busbarCutoff),
                (c == 0) ? 16'h5 : 16'(7 - c));
        end
        // equal codes in both fields, held, so the busbar check has work
        wr(OFS_FILTER_CFG, 8'h3f);
        repeat (2) @(negedge ref_clk);
        chk(16'(filterCfg.busbarCutoff), 16'h5);
        foreach (codes[i]) begin
            wr(OFS_START_DELAY, {2'b11, codes[i]});
            rd(OFS_START_DELAY, {2'b11, codes[i]});
            launch(1'b0, (codes[i] > 40) ? 1
                : 1 + codes[i] * STEP_CYC);
            rd(OFS_CONV_STATUS, 8'h01);
            rd(OFS_CONV_CTRL, 8'h00);
            @(posedge ref_clk);
            mainDone <= 1'b1;
            @(posedge ref_clk);
            mainDone <= 1'b0;
            #1;
            chk(16'(mainEnable), 16'h0);
        end
        wr(OFS_CONV_CTRL, 8'hfb);
        repeat (5) @(posedge ref_clk);
        chk(16'(mainEnable), 16'h0);
        for (int s = 0; s < 4; s++) begin
            wr(OFS_FILTER_CFG, {2'(s), 6'h00});
            launch(1'b1, (s == 2) ? 21 : (s == 1) ? 31 : 41);
            rd(OFS_CONV_STATUS, 8'h02);
        end
        g = 9'($random(seed));
        o = 7'($random(seed));
        wr(OFS_GAIN_LOW, g[7:0]);
        wr(OFS_GAIN_OFFSET, {g[8], o});
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            x = (i == 0) ? 16'h7fff : (i == 1) ? 16'h8000
                : 16'($random(seed));
            corrQ.push_back(corr(x, g, o));
            sampleValid <= 1'b1;
            sampleIn <= x;
        end
        @(posedge ref_clk);
        sampleValid <= 1'b0;
        // zero trims must pass a sample through untouched
        wr(OFS_GAIN_LOW, 8'h00);
        wr(OFS_GAIN_OFFSET, 8'h00);
        @(posedge ref_clk);
        corrQ.push_back(corr(16'h1234, 9'h000, 7'h00));
        sampleValid <= 1'b1;
        sampleIn <= 16'h1234;
        @(posedge ref_clk);
        sampleValid <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(16'(corrQ.size()), 16'h0);
        tally_and_finish();
    end
endmodule
